/* rtl/operand_pkg.sv */
`default_nettype none
package operand_pkg;
    localparam logic [7:0] special_function_register_base = 8'h80;
    localparam logic [7:0] bit_ram_base = 8'h20;
    localparam logic [1:0] one_cycle = 2'h1;
    localparam logic [1:0] two_cycle = 2'h2;

    typedef enum logic [2:0] {
        cls_arith, cls_logic, cls_xfer, cls_bool, cls_branch
    } instr_class_t;

    typedef enum logic [3:0] {
        mode_none, mode_direct, mode_ind8, mode_ind16, mode_reg, mode_implied,
        mode_imm, mode_indexed, mode_bit
    } addr_mode_t;

    typedef enum logic [2:0] {
        space_none, space_iram, space_special_function_register, space_xram, space_code,
        space_const
    } mem_space_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] byte1;
        logic [7:0] byte2;
    } instr_t;

    typedef struct packed {
        logic [7:0] acc;
        logic [15:0] data_pointer;
        logic [7:0] r0;
        logic [7:0] r1;
        logic [1:0] bank;
    } core_state_t;

    typedef struct packed {
        instr_class_t iclass;
        addr_mode_t mode;
        mem_space_t space;
        logic [15:0] addr;
        logic [7:0] imm;
        logic [2:0] bit_pos;
        logic rd;
        logic wr;
        logic [1:0] cycles;
    } operand_t;
endpackage
`default_nettype wire

/* rtl/class_decode.sv */
`default_nettype none
module class_decode (
    input wire logic [7:0] opcode_i,
    output operand_pkg::instr_class_t iclass_o
);
    logic [3:0] hi;
    logic [3:0] lo;
    always_comb begin
        hi = opcode_i[7:4];
        lo = opcode_i[3:0];
        iclass_o = operand_pkg::cls_xfer;
        // classic encoding partitioned into five classes
        if (lo == 4'h1 || opcode_i == 8'h02 || opcode_i == 8'h12 || opcode_i == 8'h22 ||
            opcode_i == 8'h32 || opcode_i == 8'h73 || opcode_i == 8'h00) begin
            iclass_o = operand_pkg::cls_branch;
        end else if (lo >= 4'h8 && (hi == 4'hd)) begin
            iclass_o = operand_pkg::cls_branch;
        end else if (hi <= 4'h3 && lo == 4'h0 && opcode_i != 8'h00) begin
            iclass_o = operand_pkg::cls_branch;
        end else if (opcode_i == 8'h40 || opcode_i == 8'h50 || opcode_i == 8'h60 ||
                     opcode_i == 8'h70 || opcode_i == 8'h80 || opcode_i == 8'hd5 ||
                     (hi == 4'hb && lo >= 4'h4)) begin
            iclass_o = operand_pkg::cls_branch;
        end else if (opcode_i == 8'h72 || opcode_i == 8'h82 || opcode_i == 8'h92 ||
                     opcode_i == 8'ha0 || opcode_i == 8'ha2 || opcode_i == 8'hb0 ||
                     opcode_i == 8'hb2 || opcode_i == 8'hb3 || opcode_i == 8'hc2 ||
                     opcode_i == 8'hc3 || opcode_i == 8'hd2 || opcode_i == 8'hd3) begin
            iclass_o = operand_pkg::cls_bool;
        end else if ((hi <= 4'h1 && lo >= 4'h4) || (hi >= 4'h2 && hi <= 4'h3 && lo >= 4'h4) ||
                     (hi == 4'h9 && lo >= 4'h4) || opcode_i == 8'ha3 || opcode_i == 8'ha4 ||
                     opcode_i == 8'h84 || opcode_i == 8'hd4) begin
            iclass_o = operand_pkg::cls_arith;
        end else if ((hi >= 4'h4 && hi <= 4'h6 && lo >= 4'h2) || opcode_i == 8'h03 ||
                     opcode_i == 8'h13 || opcode_i == 8'h23 || opcode_i == 8'h33 ||
                     opcode_i == 8'hc4 || opcode_i == 8'he4 || opcode_i == 8'hf4) begin
            iclass_o = operand_pkg::cls_logic;
        end
    end
endmodule
`default_nettype wire

/* rtl/operand_addressing.sv */
`default_nettype none
module operand_addressing (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic instr_valid_i,
    input wire operand_pkg::instr_t instr_i,
    input wire operand_pkg::core_state_t state_i,
    output operand_pkg::operand_t operand_o,
    output logic operand_valid_o,
    output logic [4:0] reg_addr_o
);
    operand_pkg::instr_class_t iclass;
    operand_pkg::operand_t op_d;
    operand_pkg::operand_t op_q;
    logic valid_d;
    logic valid_q;
    logic [4:0] reg_d;
    logic [4:0] reg_q;
    logic [7:0] opc;
    logic [3:0] lo;
    logic [7:0] ind8;
    logic [7:0] bitaddr;
    operand_pkg::mem_space_t direct_space;

    class_decode u_class (
        .opcode_i(instr_i.opcode),
        .iclass_o(iclass)
    );

    always_comb begin
        opc = instr_i.opcode;
        lo = opc[3:0];
        ind8 = opc[0] ? state_i.r1 : state_i.r0;
        bitaddr = instr_i.byte1;
        direct_space = operand_pkg::space_iram;
        if (instr_i.byte1 >= operand_pkg::special_function_register_base) begin
            direct_space = operand_pkg::space_special_function_register;
        end
        op_d = '0;
        op_d.iclass = iclass;
        op_d.mode = operand_pkg::mode_none;
        op_d.space = operand_pkg::space_none;
        op_d.cycles = operand_pkg::two_cycle;
        reg_d = reg_q;
        valid_d = instr_valid_i;
        if (opc == 8'he0 || opc == 8'hf0) begin
            // external data through the data pointer, accumulator only
            op_d.mode = operand_pkg::mode_ind16;
            op_d.space = operand_pkg::space_xram;
            op_d.addr = state_i.data_pointer;
            op_d.rd = (opc == 8'he0);
            op_d.wr = (opc == 8'hf0);
        end else if (opc == 8'he2 || opc == 8'he3 || opc == 8'hf2 || opc == 8'hf3) begin
            op_d.mode = operand_pkg::mode_ind8;
            op_d.space = operand_pkg::space_xram;
            op_d.addr = {8'h00, ind8};
            op_d.rd = !opc[4];
            op_d.wr = opc[4];
        end else if (opc == 8'h93 || opc == 8'h83) begin
            // lookup read only, never a write
            op_d.mode = operand_pkg::mode_indexed;
            op_d.space = operand_pkg::space_code;
            op_d.addr = (opc == 8'h93) ? state_i.data_pointer + {8'h00, state_i.acc} :
                        16'h0000 + {8'h00, state_i.acc};
            op_d.rd = 1'b1;
        end else if (iclass == operand_pkg::cls_bool || opc == 8'h10 || opc == 8'h20 ||
                     opc == 8'h30) begin
            if (opc != 8'hb3 && opc != 8'hc3 && opc != 8'hd3) begin
                op_d.mode = operand_pkg::mode_bit;
                op_d.bit_pos = bitaddr[2:0];
                op_d.rd = 1'b1;
                if (bitaddr < operand_pkg::special_function_register_base) begin
                    op_d.space = operand_pkg::space_iram;
                    op_d.addr = {8'h00, operand_pkg::bit_ram_base + {4'h0, bitaddr[6:3]}};
                end else begin
                    op_d.space = operand_pkg::space_special_function_register;
                    op_d.addr = {8'h00, bitaddr[7:3], 3'h0};
                end
            end else begin
                op_d.mode = operand_pkg::mode_implied;
                op_d.cycles = operand_pkg::one_cycle;
            end
        end else if (lo >= 4'h8 && iclass != operand_pkg::cls_branch) begin
            op_d.mode = operand_pkg::mode_reg;
            op_d.space = operand_pkg::space_iram;
            reg_d = {state_i.bank, opc[2:0]};
            op_d.addr = {11'h000, state_i.bank, opc[2:0]};
            op_d.rd = 1'b1;
            op_d.cycles = operand_pkg::one_cycle;
        end else if ((lo == 4'h6 || lo == 4'h7) && iclass != operand_pkg::cls_branch) begin
            op_d.mode = operand_pkg::mode_ind8; // indirect reaches upper RAM
            op_d.space = operand_pkg::space_iram;
            op_d.addr = {8'h00, ind8};
            op_d.rd = 1'b1;
        end else if (lo == 4'h5 && iclass != operand_pkg::cls_branch) begin
            op_d.mode = operand_pkg::mode_direct;
            op_d.space = direct_space;
            op_d.addr = {8'h00, instr_i.byte1};
            op_d.rd = 1'b1;
        end else if (lo == 4'h4 && opc[7:4] >= 4'h2 && opc[7:4] <= 4'h9 && opc != 8'h84) begin
            op_d.mode = operand_pkg::mode_imm;
            op_d.space = operand_pkg::space_const;
            op_d.imm = (opc == 8'h74 || opc[7:4] <= 4'h3 || opc[7:4] == 4'h9 ||
                        opc[7:4] <= 4'h6) ? instr_i.byte1 : instr_i.byte2;
        end else if (opc[7:4] >= 4'h4 && opc[7:4] <= 4'h6 && (lo == 4'h2 || lo == 4'h3)) begin
            op_d.mode = operand_pkg::mode_direct;
            op_d.space = direct_space;
            op_d.addr = {8'h00, instr_i.byte1};
            op_d.rd = 1'b1;
            op_d.wr = 1'b1;
            op_d.imm = instr_i.byte2;
        end else if (lo == 4'h4 || opc == 8'h03 || opc == 8'h13 || opc == 8'h23 ||
                     opc == 8'h33 || opc == 8'ha3) begin
            op_d.mode = operand_pkg::mode_implied;
            op_d.cycles = operand_pkg::one_cycle;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            op_q <= '0;
            valid_q <= 1'b0;
            reg_q <= 5'h00;
        end else begin
            op_q <= op_d;
            valid_q <= valid_d;
            reg_q <= reg_d;
        end
    end

    assign operand_o = op_q;
    assign operand_valid_o = valid_q;
    assign reg_addr_o = reg_q;
endmodule
`default_nettype wire

/* verification/operand_props.sv */
`default_nettype none
module operand_props (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic instr_valid_i,
    input wire operand_pkg::instr_t instr_i,
    input wire operand_pkg::core_state_t state_i,
    input wire operand_pkg::operand_t operand_o,
    input wire logic operand_valid_o,
    input wire logic [4:0] reg_addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence took(logic [7:0] op);
        instr_valid_i && instr_i.opcode == op;
    endsequence
    valid_follow_a: assert property (1'b1 |=>
        operand_valid_o == $past(instr_valid_i))
        else $error("operand valid did not follow instruction valid");
    direct_space_a: assert property (took(8'he5) |=>
        operand_o.mode == operand_pkg::mode_direct
        && operand_o.addr == {8'h00, $past(instr_i.byte1)} && operand_o.space ==
        ($past(instr_i.byte1) >= operand_pkg::special_function_register_base
        ? operand_pkg::space_special_function_register
        : operand_pkg::space_iram)) else $error("direct operand wrong");
    ind8_sel_a: assert property (instr_valid_i && instr_i.opcode[7:1] == 7'h73 |=>
        operand_o.mode == operand_pkg::mode_ind8 && operand_o.space == operand_pkg::space_iram
        && operand_o.addr[7:0] == ($past(instr_i.opcode[0]) ? $past(state_i.r1)
        : $past(state_i.r0))) else $error("indirect 8-bit operand wrong");
    ind16_xram_a: assert property (took(8'he0) |=>
        operand_o.mode == operand_pkg::mode_ind16
        && operand_o.space == operand_pkg::space_xram && operand_o.rd
        && operand_o.addr == $past(state_i.data_pointer)) else $error("16-bit indirect wrong");
    indexed_read_a: assert property (took(8'h93) |=>
        operand_o.space == operand_pkg::space_code
        && operand_o.rd && !operand_o.wr && operand_o.mode == operand_pkg::mode_indexed
        && operand_o.addr == $past(state_i.data_pointer) + $past(state_i.acc))
        else $error("indexed read wrong");
    reg_select_a: assert property (instr_valid_i && instr_i.opcode[7:3] == 5'h1d |=>
        reg_addr_o == {$past(state_i.bank), $past(instr_i.opcode[2:0])}
        && operand_o.cycles == operand_pkg::one_cycle) else $error("register select wrong");
    reg_hold_a: assert property (took(8'he5) |=> $stable(reg_addr_o))
        else $error("register address moved on a direct opcode");
    implied_op_a: assert property (took(8'he4) |=>
        operand_o.mode == operand_pkg::mode_implied)
        else $error("implied operand wrong");
    imm_value_a: assert property (took(8'h74) |=> operand_o.mode == operand_pkg::mode_imm
        && operand_o.imm == $past(instr_i.byte1)) else $error("immediate operand wrong");
    bit_pos_a: assert property (took(8'hc2) |=> operand_o.mode == operand_pkg::mode_bit
        && operand_o.bit_pos == $past(instr_i.byte1[2:0])) else $error("bit position wrong");
    class_known_a: assert property (took(8'he4) |=>
        operand_o.iclass == operand_pkg::cls_logic)
        else $error("clear accumulator not decoded as logical");
endmodule
bind operand_addressing operand_props u_props (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .state_i(state_i),
    .operand_o(operand_o), .operand_valid_o(operand_valid_o), .reg_addr_o(reg_addr_o));
`default_nettype wire

/* verification/core_state_model.sv */
`default_nettype none
module core_state_model (
    input wire logic sys_clk_i,
    input wire logic [41:0] value_i,
    output var operand_pkg::core_state_t state_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial state_o = '0;
    // register file contents change only between sampling edges
    always @(negedge sys_clk_i) state_o <= value_i;
endmodule
`default_nettype wire

/* verification/operand_addressing_test.sv */
`default_nettype none
module operand_addressing_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic instr_valid_i = 1'b0;
    operand_pkg::instr_t instr_i = '0;
    logic [41:0] state_w = '0;
    operand_pkg::core_state_t state_i;
    operand_pkg::operand_t operand_o;
    logic operand_valid_o;
    logic [4:0] reg_addr_o;
    int miscompares = 0;
    int total_checks = 0;
    logic [15:0] rnd = 16'h0063;
    logic [4:0] exp_reg = '0;
    logic [25:0] exp_q[$];
    logic [7:0] ops[9] = '{8'he8, 8'he5, 8'he6, 8'he7, 8'he0, 8'h93, 8'h74, 8'he4, 8'hc2};
    core_state_model CSM (.sys_clk_i(sys_clk_i), .value_i(state_w), .state_o(state_i));
    operand_addressing DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .instr_valid_i(instr_valid_i), .instr_i(instr_i), .state_i(state_i),
        .operand_o(operand_o), .operand_valid_o(operand_valid_o), .reg_addr_o(reg_addr_o));
    initial forever #2.5 sys_clk_i = ~sys_clk_i;
    function automatic logic [15:0] step(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
        total_checks++;
        if (e !== g) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic do_reset(input int n);
        rst_n_i = 1'b0;
        repeat (n) @(negedge sys_clk_i);
        chk("reset outputs", 64'h0, 64'({operand_o, operand_valid_o, reg_addr_o}));
        exp_reg = '0;
        rst_n_i = 1'b1;
    endtask
    initial begin
        repeat (2000) @(posedge sys_clk_i);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        logic [7:0] op;
        logic [7:0] b;
        logic [25:0] e;
        operand_pkg::mem_space_t hi_space;
        operand_pkg::instr_class_t ecls;
        logic [1:0] ecyc;
        logic erd;
        do_reset(8);
        for (int i = 0; i < 600; i++) begin
            if (i == 300) do_reset(2);
            rnd = step(rnd);
            op = ops[rnd[3:0] % 9];
            if (op == 8'he8) op = {5'h1d, rnd[6:4]};
            instr_valid_i = (op != 8'he5) | rnd[7];
            instr_i = {op, rnd[15:8], rnd[7:0] ^ 8'h3c};
            rnd = step(rnd);
            state_w <= {rnd, rnd ^ 16'h5a5a, rnd[9:0]};
            @(posedge sys_clk_i);
            b = instr_i.byte1;
            hi_space = b[7] ? operand_pkg::space_special_function_register
                : operand_pkg::space_iram;
            case (op)
                8'he5: e = {3'b111, operand_pkg::mode_direct, hi_space, 8'h00, b};
                8'he6, 8'he7: e = {3'b111, operand_pkg::mode_ind8, operand_pkg::space_iram,
                    8'h00, op[0] ? state_i.r1 : state_i.r0};
                8'he0: e = {3'b111, operand_pkg::mode_ind16, operand_pkg::space_xram,
                    state_i.data_pointer};
                8'h93: e = {3'b111, operand_pkg::mode_indexed, operand_pkg::space_code,
                    16'(state_i.data_pointer + state_i.acc)};
                8'h74: e = {3'b110, operand_pkg::mode_imm, operand_pkg::space_const, 16'h0};
                8'he4: e = {3'b100, operand_pkg::mode_implied, 19'h0};
                8'hc2: e = {3'b111, operand_pkg::mode_bit, hi_space, 8'h00,
                    b[7] ? {b[7:3], 3'h0} : 8'h20 + b[6:3]};
                default: e = {3'b101, operand_pkg::mode_reg, 3'h0, 11'h0, state_i.bank, op[2:0]};
            endcase
            e[25] = instr_valid_i;
            if (op[7:3] == 5'h1d) exp_reg = {state_i.bank, op[2:0]};
            ecls = (op == 8'he4) ? operand_pkg::cls_logic :
                (op == 8'hc2) ? operand_pkg::cls_bool : operand_pkg::cls_xfer;
            ecyc = (op == 8'he4 || op[7:3] == 5'h1d) ? operand_pkg::one_cycle
                : operand_pkg::two_cycle;
            erd = !(op == 8'h74 || op == 8'he4);
            exp_q.push_back(e);
            @(negedge sys_clk_i);
            e = exp_q.pop_front();
            chk("operand valid", 64'(e[25]), 64'(operand_valid_o));
            chk("mode", 64'(e[22:19]), 64'(operand_o.mode));
            if (e[24]) chk("space", 64'(e[18:16]), 64'(operand_o.space));
            if (e[23]) chk("addr", 64'(e[15:0]), 64'(operand_o.addr));
            chk("reg addr", 64'(exp_reg), 64'(reg_addr_o));
            chk("class", 64'(ecls), 64'(operand_o.iclass));
            chk("cycles", 64'(ecyc), 64'(operand_o.cycles));
            chk("rd wr", 64'({erd, 1'b0}), 64'({operand_o.rd, operand_o.wr}));
            if (op == 8'h74) chk("imm", 64'(b), 64'(operand_o.imm));
            if (op == 8'hc2) chk("bit pos", 64'(b[2:0]), 64'(operand_o.bit_pos));
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
